/* include/seer_latch_if.sv */
`timescale 1ns/1ns
interface seer_latch_if;
   import seer_pkg::*;
   logic [SEER_W-1:0] set_vec;
   logic              clr;
   logic [SEER_W-1:0] mask;
   logic [SEER_W-1:0] flags;
   logic              summary;

   modport owner (output set_vec, output clr, output mask, input flags, input summary);
   modport latch (input set_vec, input clr, input mask, output flags, output summary);
endinterface

/* include/seer_pkg.sv */
package seer_pkg;

   localparam int SEER_W = 8;

   // reset values of every flag and mask register
   localparam logic [SEER_W-1:0] FLAGS_RESET = 8'h00;
   localparam logic [SEER_W-1:0] MASK_RESET  = 8'h00;

   // standard event flag positions
   localparam int STD_POWER_UP     = 7;
   localparam int STD_COMMAND_ERR  = 5;
   localparam int STD_UNPERFORMED  = 4;
   localparam int STD_QUERY_LOSS   = 2;
   localparam int STD_PENDING_DONE = 0;

   // operation event positions (also the sensing pin index)
   localparam int OP_HEATER_STABLE = 2;
   localparam int OP_RAMP_DONE     = 1;
   localparam int OP_COMPLIANCE    = 0;
   localparam int OP_USED          = 3;

   // hardware fault pin vector: bit i sets flag i
   // 5 converter comm, 4 output control, 3 overvoltage, 2 overcurrent,
   // 1 line undervoltage, 0 overtemperature
   localparam int HW_USED          = 6;

   // operational fault pin vector: bit i sets flag i
   localparam int OE_CROWBAR       = 6;
   localparam int OE_TEMP_HIGH     = 3;
   localparam int OE_USED          = 7;

   // heater fault pin vector: 1 short, 0 open
   localparam int HT_USED          = 2;

   // summary positions in the status byte
   localparam int SB_OP            = 7;
   localparam int SB_STD           = 5;
   localparam int SB_HW            = 2;
   localparam int SB_OPERR         = 1;
   localparam int SB_HEATER        = 0;

   typedef enum logic [2:0] {
      QRY_NONE,
      QRY_STD,
      QRY_STD_EN,
      QRY_OP_EN,
      QRY_OP_EVT,
      QRY_OP_COND,
      QRY_ERR_EVT,
      QRY_ERR_EN
   } seer_query_t;

   typedef enum logic [1:0] {
      RESP_IDLE,
      RESP_SECOND,
      RESP_THIRD
   } seer_resp_t;

endpackage

/* logic/seer_event_latch.sv */
`timescale 1ns/1ns
module seer_event_latch
   import seer_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   reset_n,
   seer_latch_if.latch lif
);
   logic [SEER_W-1:0] flags_r;
   logic [SEER_W-1:0] flags_nxt;

   // the set term is ORed after the clear so a same-cycle event survives
   always_comb begin
      flags_nxt = (lif.clr ? FLAGS_RESET : flags_r) | lif.set_vec;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flags_r <= FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign lif.flags   = flags_r;
   assign lif.summary = |(flags_r & lif.mask);

   property p_sticky;
      @(posedge clk) disable iff (!reset_n)
         !lif.clr |=> (flags_r & $past(flags_r)) == $past(flags_r);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

   property p_set_wins;
      @(posedge clk) disable iff (!reset_n)
         lif.clr |=> flags_r == $past(lif.set_vec);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear lost an event");

endmodule // seer_event_latch

/* logic/seer_sync.sv */
`timescale 1ns/1ns
module seer_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   assign q = q_r;

   property p_two_stage;
      @(posedge clk) disable iff (!reset_n)
         $past(reset_n) && $past(reset_n, 2) |-> q_r == $past(d, 2);
   endproperty
   a_two_stage: assert property (p_two_stage) else $error("sync delay is not two cycles");

endmodule // seer_sync

/* logic/seer_top.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Contract
// - set power-up flag (bit 7) after a power off to on transition.
// - set command error flag (bit 5) on an uninterpretable command.
// - set unperformable request flag (bit 4) on a request beyond capability.
// - set query loss flag (bit 2) when response data is lost.
// - after the completion command, set bit 0 once nothing is pending.
// - standard events reach their summary through a writable, readable mask.
// - standard event query returns the register then clears it.
// - operation bits: 2 heater stable, 1 ramp done, 0 compliance.
// - operation events reach their summary through their own readable mask.
// - operation event query reads; condition query reads and clears conditions.
// - error query returns hardware, then operational, then heater flags.
// - error query clears all three; one command sets three masks, query reads them.
// - hardware bit 5 converter comm failure, bit 4 output control failure.
// - hardware bit 3 output overvoltage, bit 2 output overcurrent above 62 A.
// - hardware bit 1 line undervoltage, bit 0 temperature above 80 C.
// - operational bit 6 held while crowbar discharges, bit 5 on quench.
// - operational bit 4 remote inhibit; bit 3 above 75 C also holds the ramp.
// - operational bit 2 line overvoltage, bit 1 external programming refused.
// - operational bit 0 on missing or corrupted calibration.
// - heater bit 1 on short circuit, bit 0 on open circuit.
// - status byte bits: 7 operation, 5 standard, 2 hardware, 1 operational, 0 heater.
// - summary bits do not latch; clearing a register clears its summary.
// - host clears a mask by writing zero; reset zeroes masks and flags.
module seer_top
   import seer_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   // fault and operation sensing pins, asynchronous
   input  wire logic [HW_USED-1:0] hw_fault_pins,
   input  wire logic [OE_USED-1:0] op_fault_pins,
   input  wire logic [HT_USED-1:0] heater_fault_pins,
   input  wire logic [OP_USED-1:0] op_condition_pins,
   // events and commands from the command parser, same clock
   input  wire logic              command_error_evt,
   input  wire logic              unperformable_evt,
   input  wire logic              query_loss_evt,
   input  wire logic              completion_cmd,
   input  wire logic              ops_pending,
   input  wire logic              std_event_query,
   input  wire logic              std_enable_write,
   input  wire logic              std_enable_query,
   input  wire logic [SEER_W-1:0] enable_data,
   input  wire logic              op_event_enable_cmd,
   input  wire logic              op_event_enable_query,
   input  wire logic              op_event_query,
   input  wire logic              op_condition_query,
   input  wire logic              error_enable_cmd,
   input  wire logic [SEER_W-1:0] hw_enable_data,
   input  wire logic [SEER_W-1:0] operr_enable_data,
   input  wire logic [SEER_W-1:0] heater_enable_data,
   input  wire logic              error_event_query,
   input  wire logic              error_enable_query,
   output logic                   resp_valid,
   output logic      [SEER_W-1:0] resp_data,
   output logic                   resp_busy,
   output logic      [SEER_W-1:0] status_summary,
   output logic                   ramp_hold
);

   //////////////////////////////////////////////////////////////////////////
   // synchronise the sensing pins
   logic [HW_USED-1:0] hw_lvl;
   logic [OE_USED-1:0] oe_lvl;
   logic [HT_USED-1:0] ht_lvl;
   logic [OP_USED-1:0] op_lvl;

   seer_sync #(.W(HW_USED)) u_sync_hw (.clk(clk), .reset_n(reset_n), .d(hw_fault_pins),
                                       .q(hw_lvl));
   seer_sync #(.W(OE_USED)) u_sync_oe (.clk(clk), .reset_n(reset_n), .d(op_fault_pins),
                                       .q(oe_lvl));
   seer_sync #(.W(HT_USED)) u_sync_ht (.clk(clk), .reset_n(reset_n), .d(heater_fault_pins),
                                       .q(ht_lvl));
   seer_sync #(.W(OP_USED)) u_sync_op (.clk(clk), .reset_n(reset_n), .d(op_condition_pins),
                                       .q(op_lvl));

   //////////////////////////////////////////////////////////////////////////
   // five event registers
   seer_latch_if std_if ();
   seer_latch_if op_if ();
   seer_latch_if hw_if ();
   seer_latch_if oe_if ();
   seer_latch_if ht_if ();

   seer_event_latch u_std (.clk(clk), .reset_n(reset_n), .lif(std_if));
   seer_event_latch u_op  (.clk(clk), .reset_n(reset_n), .lif(op_if));
   seer_event_latch u_hw  (.clk(clk), .reset_n(reset_n), .lif(hw_if));
   seer_event_latch u_oe  (.clk(clk), .reset_n(reset_n), .lif(oe_if));
   seer_event_latch u_ht  (.clk(clk), .reset_n(reset_n), .lif(ht_if));

   //////////////////////////////////////////////////////////////////////////
   // event sources: power-up, completion, operation edges
   logic               power_up_pend_r;
   logic               power_up_pend_nxt;
   logic               completion_armed_r;
   logic               completion_armed_nxt;
   logic [OP_USED-1:0] op_lvl_prev_r;
   logic [OP_USED-1:0] op_lvl_prev_nxt;
   logic               completion_done;
   logic [OP_USED-1:0] op_evt;

   always_comb begin
      // reset is the power-on model, so the flag fires once after release
      power_up_pend_nxt    = 1'b0;
      completion_done      = completion_armed_r && !ops_pending;
      completion_armed_nxt = completion_cmd || (completion_armed_r && !completion_done);
      op_lvl_prev_nxt      = op_lvl;
      // stable and ramp done are transitions; compliance is a level
      op_evt               = op_lvl & ~op_lvl_prev_r;
      op_evt[OP_COMPLIANCE] = op_lvl[OP_COMPLIANCE];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         power_up_pend_r    <= 1'b1;
         completion_armed_r <= 1'b0;
         op_lvl_prev_r      <= '0;
      end else begin
         power_up_pend_r    <= power_up_pend_nxt;
         completion_armed_r <= completion_armed_nxt;
         op_lvl_prev_r      <= op_lvl_prev_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // enable masks and the operation condition register
   logic [SEER_W-1:0] std_mask_r, std_mask_nxt;
   logic [SEER_W-1:0] op_mask_r, op_mask_nxt;
   logic [SEER_W-1:0] hw_mask_r, hw_mask_nxt;
   logic [SEER_W-1:0] oe_mask_r, oe_mask_nxt;
   logic [SEER_W-1:0] ht_mask_r, ht_mask_nxt;
   logic [SEER_W-1:0] op_cond_r, op_cond_nxt;
   seer_query_t       qry;

   always_comb begin
      std_mask_nxt = std_enable_write ? enable_data : std_mask_r;
      op_mask_nxt  = op_event_enable_cmd ? enable_data : op_mask_r;
      hw_mask_nxt  = error_enable_cmd ? hw_enable_data : hw_mask_r;
      oe_mask_nxt  = error_enable_cmd ? operr_enable_data : oe_mask_r;
      ht_mask_nxt  = error_enable_cmd ? heater_enable_data : ht_mask_r;
      // a condition seen in the clearing cycle stays latched
      op_cond_nxt  = ((qry == QRY_OP_COND) ? FLAGS_RESET : op_cond_r)
                     | SEER_W'(op_lvl);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         std_mask_r <= MASK_RESET;
         op_mask_r  <= MASK_RESET;
         hw_mask_r  <= MASK_RESET;
         oe_mask_r  <= MASK_RESET;
         ht_mask_r  <= MASK_RESET;
         op_cond_r  <= FLAGS_RESET;
      end else begin
         std_mask_r <= std_mask_nxt;
         op_mask_r  <= op_mask_nxt;
         hw_mask_r  <= hw_mask_nxt;
         oe_mask_r  <= oe_mask_nxt;
         ht_mask_r  <= ht_mask_nxt;
         op_cond_r  <= op_cond_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // event register wiring
   always_comb begin
      std_if.set_vec                   = FLAGS_RESET;
      std_if.set_vec[STD_POWER_UP]     = power_up_pend_r;
      std_if.set_vec[STD_COMMAND_ERR]  = command_error_evt;
      std_if.set_vec[STD_UNPERFORMED]  = unperformable_evt;
      std_if.set_vec[STD_QUERY_LOSS]   = query_loss_evt;
      std_if.set_vec[STD_PENDING_DONE] = completion_done;
      std_if.clr  = (qry == QRY_STD);
      std_if.mask = std_mask_r;
      op_if.set_vec = SEER_W'(op_evt);
      op_if.clr     = 1'b0;
      op_if.mask    = op_mask_r;
      // fault flags are level set: a standing fault reappears after a clear
      hw_if.set_vec = SEER_W'(hw_lvl);
      oe_if.set_vec = SEER_W'(oe_lvl);
      ht_if.set_vec = SEER_W'(ht_lvl);
      hw_if.clr     = (qry == QRY_ERR_EVT);
      oe_if.clr     = (qry == QRY_ERR_EVT);
      ht_if.clr     = (qry == QRY_ERR_EVT);
      hw_if.mask    = hw_mask_r;
      oe_if.mask    = oe_mask_r;
      ht_if.mask    = ht_mask_r;
   end

   always_comb begin
      status_summary            = 8'h00;
      status_summary[SB_OP]     = op_if.summary;
      status_summary[SB_STD]    = std_if.summary;
      status_summary[SB_HW]     = hw_if.summary;
      status_summary[SB_OPERR]  = oe_if.summary;
      status_summary[SB_HEATER] = ht_if.summary;
   end

   assign ramp_hold = oe_lvl[OE_TEMP_HIGH];

   //////////////////////////////////////////////////////////////////////////
   // query arbitration and response sequencer
   seer_resp_t        resp_state_r, resp_state_nxt;
   logic              resp_valid_r, resp_valid_nxt;
   logic [SEER_W-1:0] resp_data_r, resp_data_nxt;
   logic [SEER_W-1:0] word2_r, word2_nxt;
   logic [SEER_W-1:0] word3_r, word3_nxt;

   // queries are refused while a three-word answer is going out
   always_comb begin
      qry = QRY_NONE;
      if (resp_state_r != RESP_IDLE) begin
         qry = QRY_NONE;
      end else if (std_event_query) begin
         qry = QRY_STD;
      end else if (std_enable_query) begin
         qry = QRY_STD_EN;
      end else if (op_event_enable_query) begin
         qry = QRY_OP_EN;
      end else if (op_event_query) begin
         qry = QRY_OP_EVT;
      end else if (op_condition_query) begin
         qry = QRY_OP_COND;
      end else if (error_event_query) begin
         qry = QRY_ERR_EVT;
      end else if (error_enable_query) begin
         qry = QRY_ERR_EN;
      end
   end

   always_comb begin
      resp_state_nxt = resp_state_r;
      resp_valid_nxt = 1'b0;
      resp_data_nxt  = resp_data_r;
      word2_nxt      = word2_r;
      word3_nxt      = word3_r;
      case (resp_state_r)
         RESP_IDLE: begin
            resp_valid_nxt = (qry != QRY_NONE);
            case (qry)
               QRY_STD:     resp_data_nxt = std_if.flags;
               QRY_STD_EN:  resp_data_nxt = std_mask_r;
               QRY_OP_EN:   resp_data_nxt = op_mask_r;
               QRY_OP_EVT:  resp_data_nxt = op_if.flags;
               QRY_OP_COND: resp_data_nxt = op_cond_r;
               QRY_ERR_EVT: begin
                  resp_data_nxt  = hw_if.flags;
                  word2_nxt      = oe_if.flags;
                  word3_nxt      = ht_if.flags;
                  resp_state_nxt = RESP_SECOND;
               end
               QRY_ERR_EN: begin
                  resp_data_nxt  = hw_mask_r;
                  word2_nxt      = oe_mask_r;
                  word3_nxt      = ht_mask_r;
                  resp_state_nxt = RESP_SECOND;
               end
               default: resp_data_nxt = resp_data_r;
            endcase
         end
         RESP_SECOND: begin
            resp_valid_nxt = 1'b1;
            resp_data_nxt  = word2_r;
            resp_state_nxt = RESP_THIRD;
         end
         RESP_THIRD: begin
            resp_valid_nxt = 1'b1;
            resp_data_nxt  = word3_r;
            resp_state_nxt = RESP_IDLE;
         end
         default: resp_state_nxt = RESP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         resp_state_r <= RESP_IDLE;
         resp_valid_r <= 1'b0;
         resp_data_r  <= FLAGS_RESET;
         word2_r      <= FLAGS_RESET;
         word3_r      <= FLAGS_RESET;
      end else begin
         resp_state_r <= resp_state_nxt;
         resp_valid_r <= resp_valid_nxt;
         resp_data_r  <= resp_data_nxt;
         word2_r      <= word2_nxt;
         word3_r      <= word3_nxt;
      end
   end

   assign resp_valid = resp_valid_r;
   assign resp_data  = resp_data_r;
   assign resp_busy  = (resp_state_r != RESP_IDLE);

   //////////////////////////////////////////////////////////////////////////
   // checks
   property p_power_up;
      @(posedge clk) disable iff (!reset_n)
         $fell(power_up_pend_r) |-> std_if.flags[STD_POWER_UP];
   endproperty
   a_power_up: assert property (p_power_up) else $error("power-up flag missing");

   property p_parser_events;
      @(posedge clk) disable iff (!reset_n)
         command_error_evt || unperformable_evt || query_loss_evt |=>
            (!$past(command_error_evt) || std_if.flags[STD_COMMAND_ERR])
            && (!$past(unperformable_evt) || std_if.flags[STD_UNPERFORMED])
            && (!$past(query_loss_evt) || std_if.flags[STD_QUERY_LOSS]);
   endproperty
   a_parser_events: assert property (p_parser_events) else $error("parser event lost");

   sequence s_completion_armed;
      completion_cmd ##1 !ops_pending;
   endsequence
   property p_completion;
      @(posedge clk) disable iff (!reset_n)
         s_completion_armed |=> std_if.flags[STD_PENDING_DONE];
   endproperty
   a_completion: assert property (p_completion) else $error("completion flag not set");

   property p_std_summary;
      @(posedge clk) disable iff (!reset_n)
         std_enable_write |=> status_summary[SB_STD] == |(std_if.flags & $past(enable_data));
   endproperty
   a_std_summary: assert property (p_std_summary) else $error("standard summary wrong");

   property p_std_read;
      @(posedge clk) disable iff (!reset_n)
         qry == QRY_STD |=> resp_valid_r && resp_data_r == $past(std_if.flags)
            && std_if.flags == $past(std_if.set_vec);
   endproperty
   a_std_read: assert property (p_std_read) else $error("standard read-clear wrong");

   property p_op_rise;
      @(posedge clk) disable iff (!reset_n)
         $rose(op_lvl[OP_RAMP_DONE]) |=> op_if.flags[OP_RAMP_DONE];
   endproperty
   a_op_rise: assert property (p_op_rise) else $error("ramp done event lost");

   sequence s_err_words;
      resp_valid_r && resp_data_r == $past(hw_if.flags)
      ##1 resp_valid_r && resp_data_r == $past(oe_if.flags, 2)
      ##1 resp_valid_r && resp_data_r == $past(ht_if.flags, 3);
   endsequence
   property p_err_order;
      @(posedge clk) disable iff (!reset_n)
         qry == QRY_ERR_EVT |=> s_err_words;
   endproperty
   a_err_order: assert property (p_err_order) else $error("error words out of order");

   property p_err_clear;
      @(posedge clk) disable iff (!reset_n)
         qry == QRY_ERR_EVT && hw_if.set_vec == FLAGS_RESET |=> hw_if.flags == FLAGS_RESET;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error query did not clear");

   property p_crowbar;
      @(posedge clk) disable iff (!reset_n)
         oe_lvl[OE_CROWBAR] |=> oe_if.flags[OE_CROWBAR] ##1 oe_if.flags[OE_CROWBAR];
   endproperty
   a_crowbar: assert property (p_crowbar) else $error("crowbar flag not held");

   property p_mask_zero;
      @(posedge clk) disable iff (!reset_n)
         error_enable_cmd |=> hw_mask_r == $past(hw_enable_data)
            && ht_mask_r == $past(heater_enable_data);
   endproperty
   a_mask_zero: assert property (p_mask_zero) else $error("error masks not written");

endmodule // seer_top

/* testbench/seer_host_model.sv */
`timescale 1ns/1ns
module seer_host_model
   import seer_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resp_valid,
   input  wire logic [SEER_W-1:0] resp_data,
   output logic      [9:0]        strobe,
   output logic      [SEER_W-1:0] wdata
);
   logic [SEER_W-1:0] words [3];

   initial begin
      strobe = 10'h000;
      wdata  = 8'h00;
   end

   // one strobe per request, held with its data up to the taking edge;
   // a missing answer word is stored as unknown so it can never match
   task automatic issue(input int sel, input logic [SEER_W-1:0] d, input int n);
      @(posedge clk);
      strobe[sel] <= 1'b1;
      wdata       <= d;   // a zero data word clears a mask
      @(posedge clk);
      strobe[sel] <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         words[i] = resp_valid ? resp_data : 8'hxx;
      end
   endtask
endmodule // seer_host_model

/* testbench/tb_status_error_event_registers.sv */
`timescale 1ns/1ns
module tb_status_error_event_registers
   import seer_pkg::*;
   ();
   logic       clk = 1'b0, reset_n = 1'b0, pend = 1'b0, rv, busy, hold;
   logic [5:0] hw = 6'h00;
   logic [6:0] opf = 7'h00;
   logic [1:0] ht = 2'h0;
   logic [2:0] pending_done_flag = 3'h0;
   logic [3:0] ev = 4'h0;
   logic [7:0] hwe = 8'h00, oee = 8'h00, hte = 8'h00, rd, ss, wdata;
   logic [9:0] strobe;
   logic [5:0] hwp [2] = '{6'h2a, 6'h15};
   logic [6:0] oep [2] = '{7'h55, 7'h2a};
   logic [1:0] htp [2] = '{2'h2, 2'h1};
   int         failures = 0, cmp_count = 0, cyc = 0;

   always #5 clk = ~clk;

   seer_host_model host (.clk(clk), .resp_valid(rv), .resp_data(rd), .strobe(strobe),
      .wdata(wdata));

   seer_top dut (.clk(clk), .reset_n(reset_n), .hw_fault_pins(hw), .op_fault_pins(opf),
      .heater_fault_pins(ht), .op_condition_pins(pending_done_flag), .command_error_evt(ev[0]),
      .unperformable_evt(ev[1]), .query_loss_evt(ev[2]), .completion_cmd(ev[3]),
      .ops_pending(pend), .std_event_query(strobe[0]), .std_enable_write(strobe[1]),
      .std_enable_query(strobe[2]), .enable_data(wdata), .op_event_enable_cmd(strobe[3]),
      .op_event_enable_query(strobe[4]), .op_event_query(strobe[5]),
      .op_condition_query(strobe[6]), .error_enable_cmd(strobe[7]),
      .hw_enable_data(hwe), .operr_enable_data(oee), .heater_enable_data(hte),
      .error_event_query(strobe[8]), .error_enable_query(strobe[9]), .resp_valid(rv),
      .resp_data(rd), .resp_busy(busy), .status_summary(ss), .ramp_hold(hold));

   ///////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic pulse(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
   endtask

   task automatic waitn(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ceiling is about ten times the length of the sequence below
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 1200) begin
         failures++;
         report_and_stop();
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   initial begin
      waitn(3);
      reset_n <= 1'b1;
      chk(ss, 8'h00);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h80);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h00);
      pend <= 1'b1;
      for (int k = 0; k < 4; k++) pulse(k);
      host.issue(1, 8'h20, 0);
      waitn(1);
      chk(ss, 8'h20);
      host.issue(2, 8'h00, 1);
      chk(host.words[0], 8'h20);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h34);
      chk(ss, 8'h00);
      pend <= 1'b0;
      waitn(3);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h01);
      // event strobed in the very cycle its register is read and cleared
      fork
         host.issue(0, 8'h00, 1);
         pulse(0);
      join
      chk(host.words[0], 8'h00);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h20);
      hwe <= 8'h0c;
      oee <= 8'h0c;
      hte <= 8'h01;
      host.issue(7, 8'h00, 0);
      host.issue(9, 8'h00, 3);
      chk(host.words[0], 8'h0c);
      chk(host.words[1], 8'h0c);
      chk(host.words[2], 8'h01);
      // a triple keeps the query port busy for two cycles after its take
      host.issue(9, 8'h00, 0);
      for (int b = 0; b < 3; b++) begin
         waitn(1);
         chk({7'h00, busy}, (b < 2) ? 8'h01 : 8'h00);
      end
      for (int p = 0; p < 2; p++) begin
         hw  <= hwp[p];
         opf <= oep[p];
         ht  <= htp[p];
         waitn(5);
         chk({7'h00, hold}, {7'h00, oep[p][3]});
         chk(ss, (p == 1) ? 8'h07 : 8'h06);
         hw  <= 6'h00;
         opf <= 7'h00;
         ht  <= 2'h0;
         waitn(4);
         host.issue(8, 8'h00, 3);
         chk(host.words[0], {2'b00, hwp[p]});
         chk(host.words[1], {1'b0, oep[p]});
         chk(host.words[2], {6'h00, htp[p]});
         host.issue(8, 8'h00, 3);
         chk(host.words[0] | host.words[1] | host.words[2], 8'h00);
         chk(ss, 8'h00);
      end
      pending_done_flag <= 3'h7;
      waitn(5);
      pending_done_flag <= 3'h0;
      waitn(4);
      host.issue(3, 8'h02, 0);
      waitn(1);
      chk(ss, 8'h80);
      host.issue(4, 8'h00, 1);
      chk(host.words[0], 8'h02);
      for (int r = 0; r < 2; r++) begin
         host.issue(5, 8'h00, 1);
         chk(host.words[0], 8'h07);
      end
      host.issue(6, 8'h00, 1);
      chk(host.words[0], 8'h07);
      host.issue(6, 8'h00, 1);
      chk(host.words[0], 8'h00);
      host.issue(3, 8'h00, 0);
      waitn(1);
      chk(ss, 8'h00);
      // second power-on: masks return to zero and the power-up flag fires again
      reset_n <= 1'b0;
      waitn(3);
      reset_n <= 1'b1;
      host.issue(2, 8'h00, 1);
      chk(host.words[0], 8'h00);
      host.issue(0, 8'h00, 1);
      chk(host.words[0], 8'h80);
      report_and_stop();
   end
endmodule // tb_status_error_event_registers
